// [frr_host.sv]
// Purpose: host model that drives the fifo read-port pins
// Assumes: the design passes every pin through two sync flops
// Notes:   mark is a level held across commands; p is {ren_n, sel_n, rt_n, fc_n, pc_n}
`timescale 1ns/10ps
module frr_host
    import frr_pkg::*;
(
    input  wire logic          aclk,
    output frr_pkg::frr_pins_t pins
);
    logic mark_lvl = 1'b0;
    initial pins = PINS_IDLE;
    task automatic put(input logic [4:0] p, input int n);
        @(posedge aclk);
        pins <= {p[4:3], mark_lvl, p[2:0]};
        repeat (n - 1) @(posedge aclk);
    endtask
    task automatic idle(input int n);
        put(5'h1F, n);
    endtask
    // one enabled edge, then a gap so that offset reads never come back to back
    task automatic ofs_read();
        put(5'h07, 1);
        idle(3);
    endtask
    task automatic fifo_read();
        put(5'h0F, 1);
        idle(3);
    endtask
    task automatic full_clear();
        put(5'h1D, 2);
        idle(3);
    endtask
    task automatic part_clear();
        put(5'h1E, 2);
        idle(3);
    endtask
    // callers mark only while at most six of the eight words are in use, so pointers stay apart
    task automatic set_mark(input logic m);
        mark_lvl = m;
        idle(3);
    endtask
    // reads stay disabled before and during the request
    task automatic replay_req(input int n);
        idle(2);
        put(5'h1B, n);
    endtask
endmodule

// [frr_ofs_seq.sv]
// Purpose: offset readback pointer and word selection
// Assumes: step is high only on an enabled offset read edge
// Notes:   pointer survives partial clear, only full clear rewinds it
`timescale 1ns/10ps
module frr_ofs_seq
    import frr_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              full_clear,
    input  wire logic              step,
    input  wire logic [1:0]        width_sel,
    input  wire logic              deep,
    input  wire logic [OFS_W-1:0]  empty_ofs,
    input  wire logic [OFS_W-1:0]  full_ofs,
    output logic      [2:0]        idx,
    output logic      [DATA_W-1:0] word
);
    logic [2:0]        idx_ff;
    logic [1:0]        nwords;
    logic [2:0]        last;
    logic [1:0]        part;
    logic              is_full;
    logic [DATA_W-1:0] ofs_ext;

    assign nwords = words_per_offset(width_sel, deep);
    assign last   = 3'({nwords, 1'b0} - 3'h1);
    assign idx    = idx_ff;

    always_comb begin
        is_full = (idx_ff >= 3'(nwords));
        part    = is_full ? 2'(idx_ff - 3'(nwords)) : idx_ff[1:0];
        ofs_ext = DATA_W'(is_full ? full_ofs : empty_ofs);
        case (width_sel)
            WIDTH_18: word = (ofs_ext >> (18 * part)) & 36'h00003FFFF;
            WIDTH_9:  word = (ofs_ext >> (9 * part)) & 36'h0000001FF;
            default:  word = ofs_ext;
        endcase
    end

    // wrap to the empty offset low word after the full offset high word
    always_ff @(posedge aclk) begin
        if (!aresetn || full_clear) begin
            idx_ff <= 3'h0;
        end else if (step) begin
            idx_ff <= (idx_ff >= last) ? 3'h0 : 3'(idx_ff + 3'h1);
        end
    end
endmodule

// [frr_pkg.sv]
// Purpose: shared constants, types and helpers of the fifo replay and offset readback block
// Assumes: one clock, registers reached over axi4-lite with 32-bit data
// Notes:   offsets are byte addresses of aligned 32-bit words
package frr_pkg;
    localparam int DATA_W = 36;
    localparam int OFS_W  = 20;
    localparam int ADDR_W = 8;

    localparam logic [ADDR_W-1:0] REG_CTRL      = 8'h00;
    localparam logic [ADDR_W-1:0] REG_EMPTY_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] REG_FULL_OFS  = 8'h08;
    localparam logic [ADDR_W-1:0] REG_STATUS    = 8'h0C;

    localparam int CTRL_FALL_THROUGH_MODE_BIT  = 0;
    localparam int CTRL_WIDTH_LSB = 1;
    localparam int CTRL_DEEP_BIT  = 3;
    localparam int STAT_COUNT_LSB = 0;
    localparam int STAT_REPLAY_BIT = 16;
    localparam int STAT_SETUP_BIT = 17;
    localparam int STAT_IDX_LSB   = 20;

    localparam logic [3:0]       CTRL_RST      = 4'h0;
    localparam logic [OFS_W-1:0] EMPTY_OFS_RST = 20'h0007F;
    localparam logic [OFS_W-1:0] FULL_OFS_RST  = 20'h0007F;

    localparam logic [1:0] WIDTH_36 = 2'h0;
    localparam logic [1:0] WIDTH_18 = 2'h1;
    localparam logic [1:0] WIDTH_9  = 2'h2;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef struct packed {
        logic read_en_n;
        logic offset_access_select_n;
        logic mark;
        logic replay_request_n;
        logic full_clear_n;
        logic partial_clear_n;
    } frr_pins_t;

    localparam frr_pins_t PINS_IDLE = 6'h37;

    typedef enum logic [2:0] {
        ST_NORMAL = 3'b001,
        ST_REPLAY = 3'b010,
        ST_SETUP  = 3'b100
    } frr_state_t;

    // words needed per offset for a given output width and depth class
    function automatic logic [1:0] words_per_offset(input logic [1:0] width, input logic deep);
        words_per_offset = 2'h1;
        if (width == WIDTH_18 && deep) begin
            words_per_offset = 2'h2;
        end else if (width == WIDTH_9) begin
            words_per_offset = deep ? 2'h3 : 2'h2;
        end
    endfunction
endpackage

// [frr_sync.sv]
// Purpose: two-stage synchroniser for the read-port pins
// Assumes: pins are asynchronous to aclk
// Notes:   only the second stage is visible outside
`timescale 1ns/10ps
module frr_sync
    import frr_pkg::*;
(
    input  wire logic      aclk,
    input  wire logic      aresetn,
    input  frr_pkg::frr_pins_t pins_in,
    output frr_pkg::frr_pins_t pins_out
);
    frr_pins_t meta_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_ff  <= PINS_IDLE;
            pins_out <= PINS_IDLE;
        end else begin
            meta_ff  <= pins_in;
            pins_out <= meta_ff;
        end
    end
endmodule

// [frr_top.sv]
// Purpose: read-port control of a fifo with offset readback and replay from mark
// Assumes: write side is same-clock logic; read-port pins are asynchronous
// Notes:   bus sizing of fifo data is not modelled, words are full width
//
// The implementer's own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
module frr_top
    import frr_pkg::*;
#(
    parameter int DEPTH = 1024
) (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [ADDR_W-1:0]    s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    input  frr_pkg::frr_pins_t        read_pins,
    input  wire logic [DATA_W-1:0]    wr_data,
    input  wire logic                 wr_valid,
    output logic                      wr_ready,
    output logic [DATA_W-1:0]         read_data_bus,
    output logic                      empty_flag_n,
    output logic                      almost_empty_flag_n,
    output logic                      almost_full_flag_n
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_P = (AW+1)'(DEPTH);

    frr_pins_t         pins_s;
    frr_state_t        state_ff;
    logic [3:0]        ctrl_ff;
    logic [OFS_W-1:0]  empty_ofs_ff;
    logic [OFS_W-1:0]  full_ofs_ff;
    logic [DATA_W-1:0] mem [DEPTH];
    logic [AW:0]       wr_ptr_ff;
    logic [AW:0]       rd_ptr_ff;
    logic [AW:0]       mark_ptr_ff;
    logic [AW:0]       count;
    logic [AW:0]       used;
    logic              ov_ff;
    logic              fall_through_mode;
    logic              fc;
    logic              pc;
    logic              run;
    logic              step;
    logic              std_rd;
    logic              ft_load;
    logic              wr_go;
    logic              mark_ok;
    logic [2:0]        ofs_idx;
    logic [DATA_W-1:0] ofs_word;
    logic [31:0]       rd_word;
    logic              rd_hit;

    frr_sync u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .pins_in  (read_pins),
        .pins_out (pins_s)
    );

    assign fc   = !pins_s.full_clear_n;
    assign pc   = !pins_s.partial_clear_n;
    assign run  = !fc && !pc;
    assign fall_through_mode = ctrl_ff[CTRL_FALL_THROUGH_MODE_BIT];
    // an offset readback and the fifo read share the read-enable edge; offset wins
    assign step = run && !pins_s.read_en_n && !pins_s.offset_access_select_n;

    frr_ofs_seq u_ofs (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .full_clear (fc),
        .step       (step),
        .width_sel  (ctrl_ff[CTRL_WIDTH_LSB+:2]),
        .deep       (ctrl_ff[CTRL_DEEP_BIT]),
        .empty_ofs  (empty_ofs_ff),
        .full_ofs   (full_ofs_ff),
        .idx        (ofs_idx),
        .word       (ofs_word)
    );

    // ---------------- fifo pointers and occupancy ----------------
    assign count = wr_ptr_ff - rd_ptr_ff;
    assign used  = (state_ff == ST_NORMAL) ? count : wr_ptr_ff - mark_ptr_ff;
    assign wr_ready = (used != DEPTH_P);
    assign wr_go = run && wr_valid && wr_ready;
    assign std_rd = run && !fall_through_mode && !step && !pins_s.read_en_n && count != '0
                    && state_ff != ST_SETUP;
    // the first word after setup falls through with no read enable
    assign ft_load = run && fall_through_mode && !step && count != '0 && state_ff != ST_SETUP
                     && (!ov_ff || !pins_s.read_en_n);
    assign mark_ok = fall_through_mode ? ov_ff : (count != '0);

    always_ff @(posedge aclk) begin
        if (wr_go) begin
            mem[wr_ptr_ff[AW-1:0]] <= wr_data;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || !run) begin
            wr_ptr_ff <= '0;
        end else if (wr_go) begin
            wr_ptr_ff <= wr_ptr_ff + 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || !run) begin
            rd_ptr_ff <= '0;
        end else if (state_ff == ST_SETUP || (state_ff == ST_REPLAY && pins_s.mark
                     && !pins_s.replay_request_n)) begin
            rd_ptr_ff <= mark_ptr_ff;
        end else if (std_rd || ft_load) begin
            rd_ptr_ff <= rd_ptr_ff + 1'b1;
        end
    end

    // ---------------- replay state ----------------
    always_ff @(posedge aclk) begin
        if (!aresetn || !run) begin
            state_ff <= ST_NORMAL;
        end else begin
            case (state_ff)
                ST_NORMAL: if (pins_s.mark && mark_ok) state_ff <= ST_REPLAY;
                ST_REPLAY: begin
                    if (!pins_s.mark) begin
                        state_ff <= ST_NORMAL;
                    end else if (!pins_s.replay_request_n) begin
                        state_ff <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    if (!pins_s.mark) begin
                        state_ff <= ST_NORMAL;
                    end else if (pins_s.replay_request_n) begin
                        state_ff <= ST_REPLAY;
                    end
                end
                default: state_ff <= ST_NORMAL;
            endcase
        end
    end

    // the word already in the output register is the first one to replay
    always_ff @(posedge aclk) begin
        if (!aresetn || !run) begin
            mark_ptr_ff <= '0;
        end else if (state_ff == ST_NORMAL && pins_s.mark && mark_ok) begin
            mark_ptr_ff <= rd_ptr_ff - 1'b1;
        end
    end

    // ---------------- output register ----------------
    always_ff @(posedge aclk) begin
        if (!aresetn || !run) begin
            read_data_bus <= '0;
        end else if (step) begin
            read_data_bus <= ofs_word;
        end else if (std_rd || ft_load) begin
            read_data_bus <= mem[rd_ptr_ff[AW-1:0]];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || !run) begin
            ov_ff <= 1'b0;
        end else if (state_ff == ST_SETUP || (state_ff == ST_REPLAY && pins_s.mark
                     && !pins_s.replay_request_n)) begin
            ov_ff <= 1'b0;
        end else if (ft_load) begin
            ov_ff <= 1'b1;
        end else if (!step && !pins_s.read_en_n) begin
            ov_ff <= 1'b0;
        end
    end

    // in fall-through mode this pin reads as output valid, active low
    assign empty_flag_n = fall_through_mode ? !ov_ff : (count != '0 && state_ff != ST_SETUP);
    assign almost_empty_flag_n = (OFS_W'(count) > empty_ofs_ff);
    assign almost_full_flag_n  = (OFS_W'(DEPTH_P - used) > full_ofs_ff);

    // ---------------- axi4-lite slave ----------------
    // address and data are taken together; a lone channel waits for its partner
    assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_wready  = s_axi_awready;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff      <= CTRL_RST;
            empty_ofs_ff <= EMPTY_OFS_RST;
            full_ofs_ff  <= FULL_OFS_RST;
        end else if (s_axi_awready && s_axi_wstrb[0]) begin
            case (s_axi_awaddr)
                REG_CTRL:      ctrl_ff <= s_axi_wdata[3:0];
                REG_EMPTY_OFS: empty_ofs_ff <= s_axi_wdata[OFS_W-1:0];
                REG_FULL_OFS:  full_ofs_ff <= s_axi_wdata[OFS_W-1:0];
                default:       ctrl_ff <= ctrl_ff;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (s_axi_awready) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (s_axi_awaddr == REG_CTRL || s_axi_awaddr == REG_EMPTY_OFS
                             || s_axi_awaddr == REG_FULL_OFS || s_axi_awaddr == REG_STATUS)
                            ? RESP_OKAY : RESP_DECERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_comb begin
        rd_word = 32'h00000000;
        rd_hit  = 1'b1;
        case (s_axi_araddr)
            REG_CTRL:      rd_word[3:0] = ctrl_ff;
            REG_EMPTY_OFS: rd_word[OFS_W-1:0] = empty_ofs_ff;
            REG_FULL_OFS:  rd_word[OFS_W-1:0] = full_ofs_ff;
            REG_STATUS: begin
                rd_word[STAT_COUNT_LSB+:16] = 16'(count);
                rd_word[STAT_REPLAY_BIT]    = (state_ff != ST_NORMAL);
                rd_word[STAT_SETUP_BIT]     = (state_ff == ST_SETUP);
                rd_word[STAT_IDX_LSB+:3]    = ofs_idx;
            end
            default:       rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_DECERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ---------------- assertions ----------------
    sequence s_rewind;
        state_ff == ST_REPLAY && pins_s.mark && !pins_s.replay_request_n && run;
    endsequence

    a_ofs_word_out: assert property (@(posedge aclk) disable iff (!aresetn)
        step |=> read_data_bus == $past(ofs_word))
        else $error("offset word not presented");

    a_ofs_idx_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (!step && !fc) |=> $stable(ofs_idx))
        else $error("offset pointer moved without enabled read");

    a_partial_keeps: assert property (@(posedge aclk) disable iff (!aresetn)
        (pc && !fc) |=> ofs_idx == $past(ofs_idx))
        else $error("partial clear disturbed offset pointer");

    a_replay_entry: assert property (@(posedge aclk) disable iff (!aresetn)
        (run && state_ff == ST_NORMAL && pins_s.mark && mark_ok)
        |=> state_ff == ST_REPLAY && mark_ptr_ff == $past(rd_ptr_ff) - 1'b1)
        else $error("replay mode not entered");

    a_replay_exit: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_ff != ST_NORMAL && !pins_s.mark) |=> state_ff == ST_NORMAL)
        else $error("replay mode not left on mark low");

    a_setup_rewind: assert property (@(posedge aclk) disable iff (!aresetn)
        s_rewind |=> state_ff == ST_SETUP && rd_ptr_ff == $past(mark_ptr_ff))
        else $error("read pointer not returned to mark");

    a_setup_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_rewind ##1 1'b1) |-> empty_flag_n == fall_through_mode)
        else $error("flag not showing replay setup");

    a_mark_guard: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_ff != ST_NORMAL && wr_ptr_ff - mark_ptr_ff == DEPTH_P)
        |-> !wr_ready ##1 (wr_ptr_ff == $past(wr_ptr_ff) || !run))
        else $error("write passed the marked location");

    a_ft_first_word: assert property (@(posedge aclk) disable iff (!aresetn)
        (fall_through_mode && state_ff == ST_SETUP && pins_s.mark && pins_s.replay_request_n && run
         && count != '0) ##1 (run && pins_s.mark && pins_s.replay_request_n && !step)
        |=> ov_ff && !empty_flag_n)
        else $error("first marked word did not fall through");
endmodule

// [tb_top.sv]
// Purpose: self-checking bench for offset readback and replay from mark
// Assumes: registers over axi4-lite, read pins through the host model
// Notes:   small depth so the mark guard on writes is reached quickly
`timescale 1ns/10ps
module tb_top;
    import frr_pkg::*;
    localparam int DEPTH = 8;
    localparam logic [OFS_W-1:0] EOFS = 20'h2A5C3;
    localparam logic [OFS_W-1:0] FOFS = 20'h1E1D4;
    localparam logic [3:0] CFG [6] = '{4'h0, 4'h2, 4'hA, 4'h4, 4'hC, 4'h1};
    localparam int SLICE [6] = '{36, 18, 18, 9, 9, 36};
    localparam int NWRD [6] = '{1, 1, 2, 2, 3, 1};
    logic              aclk;
    logic              aresetn;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [31:0]       wdata, rdata;
    logic [3:0]        wstrb;
    logic              awvalid, wvalid, bready;
    logic              arvalid, rready;
    logic              awready, wready, bvalid, arready, rvalid;
    logic [1:0]        bresp, rresp;
    frr_pins_t         pins;
    logic [DATA_W-1:0] wr_data, rdb;
    logic              wr_valid, wr_ready, ef_n, ae_n, af_n;
    int                error_cnt = 0, checks = 0, cyc = 0;

    frr_top #(.DEPTH(DEPTH)) frr_top_inst (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .read_pins(pins), .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
        .read_data_bus(rdb), .empty_flag_n(ef_n), .almost_empty_flag_n(ae_n),
        .almost_full_flag_n(af_n));
    frr_host frr_host_inst (.aclk(aclk), .pins(pins));

    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 30000) begin
            error_cnt++;
            $display("BAD %0t run did not finish", $time);
            give_verdict();
        end
    end
    task automatic chk_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        @(posedge aclk);
        while (awready !== 1'b1) @(posedge aclk);
        awvalid <= 1'b0;
        wvalid  <= 1'b0;
        while (bvalid !== 1'b1) @(posedge aclk);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        @(posedge aclk);
        while (arready !== 1'b1) @(posedge aclk);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge aclk);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic rd_reg(input logic [ADDR_W-1:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(a, d, r);
        chk_word({4'h0, d}, {4'h0, ed});
        chk_word({34'h0, r}, {34'h0, er});
    endtask
    // the write port gives up after a few edges, so a refusal cannot hang the bench
    task automatic push(input logic [DATA_W-1:0] d, output logic ok);
        int t;
        @(posedge aclk);
        wr_data  <= d;
        wr_valid <= 1'b1;
        ok = 1'b0;
        for (t = 0; t < 4 && !ok; t++) begin
            @(posedge aclk);
            ok = (wr_ready === 1'b1);
        end
        wr_valid <= 1'b0;
    endtask
    task automatic ofs_chk(input logic [DATA_W-1:0] exp);
        frr_host_inst.ofs_read();
        #1;
        chk_word(rdb, exp);
    endtask
    task automatic rd_chk(input logic [DATA_W-1:0] exp);
        frr_host_inst.fifo_read();
        #1;
        chk_word(rdb, exp);
    endtask
    task automatic replay_chk(input logic setup_lvl);
        frr_host_inst.replay_req(4);
        #1;
        chk_bit(ef_n, setup_lvl);
        frr_host_inst.idle(6);
        #1;
        chk_bit(ef_n, !setup_lvl);
    endtask
    function automatic logic [DATA_W-1:0] ofs_word(input logic [OFS_W-1:0] o, input int s,
                                                   input int k);
        return ({16'h0000, o} >> (k * s)) & ~({DATA_W{1'b1}} << s);
    endfunction
    function automatic logic [DATA_W-1:0] dw(input int i);
        return 36'h5A5A00000 + DATA_W'(i);
    endfunction

    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        logic        ok;
        int          n, k, i;
        aresetn  <= 1'b0;
        awaddr   <= '0;
        araddr   <= '0;
        wdata    <= '0;
        wstrb    <= 4'hF;
        awvalid  <= 1'b0;
        wvalid   <= 1'b0;
        bready   <= 1'b0;
        arvalid  <= 1'b0;
        rready   <= 1'b0;
        wr_data  <= '0;
        wr_valid <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        #1;
        chk_word(rdb, '0);
        chk_bit(ef_n, 1'b0);
        rd_reg(REG_CTRL, 32'h0, RESP_OKAY);
        rd_reg(REG_EMPTY_OFS, {12'h000, EMPTY_OFS_RST}, RESP_OKAY);
        rd_reg(8'h10, 32'h0, RESP_DECERR);
        axi_wr(8'h10, 32'h00000001, r);
        chk_word({34'h0, r}, {34'h0, RESP_DECERR});
        axi_wr(REG_EMPTY_OFS, {12'h000, EOFS}, r);
        axi_wr(REG_FULL_OFS, {12'h000, FOFS}, r);
        rd_reg(REG_FULL_OFS, {12'h000, FOFS}, RESP_OKAY);
        // a write with byte lane 0 disabled is answered but changes nothing
        wstrb <= 4'h0;
        axi_wr(REG_FULL_OFS, 32'h00000000, r);
        wstrb <= 4'hF;
        chk_word({34'h0, r}, {34'h0, RESP_OKAY});
        rd_reg(REG_FULL_OFS, {12'h000, FOFS}, RESP_OKAY);
        $display("test reset and registers done");
        for (i = 0; i < 6; i++) begin
            axi_wr(REG_CTRL, {28'h0, CFG[i]}, r);
            frr_host_inst.full_clear();
            n = NWRD[i];
            for (k = 0; k <= 2 * n; k++) begin
                ofs_chk(ofs_word(((k % (2 * n)) < n) ? EOFS : FOFS, SLICE[i], k % n));
            end
        end
        $display("test offset sequences done");
        axi_wr(REG_CTRL, 32'h0000000A, r);
        frr_host_inst.full_clear();
        ofs_chk(ofs_word(EOFS, 18, 0));
        push(dw(9), ok);
        rd_chk(dw(9));
        frr_host_inst.put(5'h17, 1);
        frr_host_inst.fifo_read();
        ofs_chk(ofs_word(EOFS, 18, 1));
        frr_host_inst.part_clear();
        ofs_chk(ofs_word(FOFS, 18, 0));
        frr_host_inst.full_clear();
        ofs_chk(ofs_word(EOFS, 18, 0));
        $display("test interrupted readback done");
        axi_wr(REG_CTRL, 32'h0, r);
        frr_host_inst.full_clear();
        for (i = 0; i < 4; i++) push(dw(i), ok);
        frr_host_inst.idle(2);
        #1;
        chk_bit(ef_n, 1'b1);
        rd_chk(dw(0));
        frr_host_inst.set_mark(1'b1);
        axi_rd(REG_STATUS, d, r);
        chk_bit(d[STAT_REPLAY_BIT], 1'b1);
        rd_chk(dw(1));
        rd_chk(dw(2));
        n = 0;
        for (i = 4; i < 9; i++) begin
            push(dw(i), ok);
            n += ok;
        end
        chk_word(DATA_W'(n), DATA_W'(DEPTH - 4));
        for (k = 0; k < 2; k++) begin
            replay_chk(1'b0);
            rd_chk(dw(0));
            rd_chk(dw(1));
        end
        frr_host_inst.set_mark(1'b0);
        axi_rd(REG_STATUS, d, r);
        chk_bit(d[STAT_REPLAY_BIT], 1'b0);
        frr_host_inst.set_mark(1'b1);
        rd_chk(dw(2));
        replay_chk(1'b0);
        rd_chk(dw(1));
        frr_host_inst.set_mark(1'b0);
        $display("test standard replay done");
        axi_wr(REG_CTRL, 32'h00000001, r);
        frr_host_inst.full_clear();
        for (i = 0; i < 3; i++) push(dw(i), ok);
        frr_host_inst.idle(3);
        #1;
        chk_word(rdb, dw(0));
        chk_bit(ef_n, 1'b0);
        frr_host_inst.set_mark(1'b1);
        axi_rd(REG_STATUS, d, r);
        chk_bit(d[STAT_REPLAY_BIT], 1'b1);
        rd_chk(dw(1));
        replay_chk(1'b1);
        chk_word(rdb, dw(0));
        rd_chk(dw(1));
        ofs_chk(ofs_word(EOFS, 36, 0));
        frr_host_inst.set_mark(1'b0);
        $display("test fall-through replay done");
        axi_wr(REG_EMPTY_OFS, 32'h00000002, r);
        axi_wr(REG_FULL_OFS, 32'h00000003, r);
        axi_wr(REG_CTRL, 32'h0, r);
        frr_host_inst.full_clear();
        // level flags: high while count is above the empty offset, free above the full one
        for (i = 0; i < 5; i++) begin
            push(dw(i), ok);
            #1;
            chk_bit(ae_n, i >= 2);
            chk_bit(af_n, i < 4);
        end
        $display("test level flags done");
        give_verdict();
    end
endmodule
